// ---- core/tcc_consts.svh ----
// constants for the timer channel control and status block
//
// Contract
// - input capture sets event flag on selected active pin edge
// - output compare or edge PWM sets flag on counter equal compare value
// - center PWM sets flag on every match, up and down count
// - interrupt request while flag set and enable bit is one
// - flag clears only after read-while-set then write zero
// - new event between read and zero write abandons the clear
// - writing one to flag has no effect; reset clears flag
// - enable bit 6 read/write, reset clears it
// - center off and mode bit 5 set gives edge PWM
// - center off, bit 5 zero: 00 capture, 01 compare
// - edge/level zero releases pin for general I/O
// - capture edge: 01 rising, 10 falling, 11 either
// - compare action: 00 none, 01 toggle, 10 low, 11 high
// - edge PWM: 10 high-true cleared on match, X1 low-true set
// - center on ignores mode bits; 10 high-true, X1 low-true
// - unsteady pin before capture may give a spurious edge
// - center select forces all channels center PWM; reset clears
// - any control/status write releases value coherency latch
`ifndef TCC_CONSTS_SVH
`define TCC_CONSTS_SVH
`define TCC_ADDR_CSR 12'h000
`define TCC_ADDR_MOD 12'h004
`define TCC_ADDR_CMP 12'h008
`define TCC_ADDR_CNT 12'h00C
`define TCC_BIT_FLAG 7
`define TCC_BIT_IE 6
`define TCC_BIT_MSB 5
`define TCC_BIT_MSA 4
`define TCC_BIT_ELSB 3
`define TCC_BIT_ELSA 2
`define TCC_BIT_CPWM 0
`define TCC_CSR_WMASK 8'h7C
`define TCC_CNT_ZERO 16'h0000
`define TCC_CNT_ONE 16'h0001
`endif

// ---- core/tcc_edge.sv ----
// pin synchroniser and edge detector for the capture input
`timescale 1ns/1ns
`default_nettype none
module tcc_edge (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // pin and edge select
    input wire logic pin_i,
    input wire logic [1:0] els,
    // detected active edge
    output logic edge_o
);
    logic s1_q, s1_d, s2_q, s2_d, s3_q, s3_d;

    always_comb begin
        s1_d = pin_i;
        s2_d = s1_q;
        s3_d = s2_q;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            s3_q <= s3_d;
        end
    end

    // only the second stage onward feeds the detector
    always_comb begin
        edge_o = (els[0] && s2_q && !s3_q) || (els[1] && !s2_q && s3_q);
    end
endmodule : tcc_edge
`default_nettype wire

// ---- core/tcc_pkg.sv ----
// types for the timer channel control and status block
package tcc_pkg;
    typedef enum logic [2:0] {
        TCC_MODE_CAPTURE,
        TCC_MODE_COMPARE,
        TCC_MODE_EPWM,
        TCC_MODE_CPWM
    } tcc_mode_t;
    typedef enum logic [1:0] {
        TCC_CLR_IDLE,
        TCC_CLR_ARMED
    } tcc_clr_t;
endpackage : tcc_pkg

// ---- core/tcc_top.sv ----
// timer channel control and status with apb slave and a small test counter
//
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/1ns
`default_nettype none
`include "tcc_consts.svh"
module tcc_top (
    // clock and reset
    input wire logic CLK,
    input wire logic SRST,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // timer pin
    input wire logic PIN_I,
    output logic PIN_O,
    output logic PIN_OE,
    // channel request and status
    output logic IRQ,
    output var tcc_pkg::tcc_mode_t MODE,
    output logic COH_RELEASE
);
    import tcc_pkg::*;

    // ****************************************
    // bus decode
    // ****************************************
    function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
        hit = (a == r);
    endfunction : hit

    logic acc, wr, rd;
    assign acc = PSEL && PENABLE;
    assign wr = acc && PWRITE;
    assign rd = acc && !PWRITE;
    assign PREADY = 1'b1;

    // ****************************************
    // state
    // ****************************************
    logic [7:0] csr_q, csr_d;
    logic cpwm_q, cpwm_d;
    logic [15:0] mod_q, mod_d, cmp_q, cmp_d, cnt_q, cnt_d;
    logic down_q, down_d;
    logic pin_q, pin_d;
    logic coh_q, coh_d;
    logic [31:0] rdata_q, rdata_d;
    logic perr_q, perr_d;
    tcc_clr_t clr_q, clr_d;
    tcc_mode_t mode;
    logic cap_edge, match, event_hit;
    logic [1:0] els;

    assign els = csr_q[`TCC_BIT_ELSB:`TCC_BIT_ELSA];

    // ****************************************
    // mode decode
    // ****************************************
    always_comb begin
        if (cpwm_q)
            mode = TCC_MODE_CPWM;
        else if (csr_q[`TCC_BIT_MSB])
            mode = TCC_MODE_EPWM;
        else if (csr_q[`TCC_BIT_MSA])
            mode = TCC_MODE_COMPARE;
        else
            mode = TCC_MODE_CAPTURE;
    end

    tcc_edge tcc_edge_inst (
        .clk(CLK),
        .srst(SRST),
        .pin_i(PIN_I),
        .els(els),
        .edge_o(cap_edge)
    );

    // ****************************************
    // counter: up, or up/down in center mode
    // ****************************************
    always_comb begin
        cnt_d = cnt_q;
        down_d = down_q;
        if (!cpwm_q) begin
            down_d = 1'b0;
            cnt_d = (cnt_q == mod_q && mod_q != `TCC_CNT_ZERO) ? `TCC_CNT_ZERO
                                                               : cnt_q + `TCC_CNT_ONE;
        end else if (down_q) begin
            if (cnt_q == `TCC_CNT_ZERO) begin
                down_d = 1'b0;
                cnt_d = cnt_q + `TCC_CNT_ONE;
            end else begin
                cnt_d = cnt_q - `TCC_CNT_ONE;
            end
        end else if (cnt_q == mod_q) begin
            down_d = 1'b1;
            cnt_d = cnt_q - `TCC_CNT_ONE;
        end else begin
            cnt_d = cnt_q + `TCC_CNT_ONE;
        end
    end

    // ****************************************
    // events
    // ****************************************
    always_comb begin
        match = (cnt_q == cmp_q);
        event_hit = 1'b0;
        unique case (mode)
            TCC_MODE_CAPTURE: event_hit = cap_edge && (els != 2'h0);
            TCC_MODE_COMPARE: event_hit = match;
            TCC_MODE_EPWM: event_hit = match;
            TCC_MODE_CPWM: event_hit = match;
        endcase
    end

    // ****************************************
    // pin output
    // ****************************************
    always_comb begin
        pin_d = pin_q;
        unique case (mode)
            TCC_MODE_CAPTURE: pin_d = pin_q;
            TCC_MODE_COMPARE: begin
                if (match) begin
                    unique case (els)
                        2'h0: pin_d = pin_q;
                        2'h1: pin_d = !pin_q;
                        2'h2: pin_d = 1'b0;
                        2'h3: pin_d = 1'b1;
                    endcase
                end
            end
            TCC_MODE_EPWM: begin
                // period restart asserts the active level, match ends it
                if (match)
                    pin_d = els[0];
                else if (cnt_q == `TCC_CNT_ZERO)
                    pin_d = !els[0];
            end
            TCC_MODE_CPWM: begin
                // only the up-count match and the down-count match flip the pin
                if (match)
                    pin_d = down_q ? !els[0] : els[0];
            end
        endcase
    end

    assign PIN_O = pin_q;
    assign PIN_OE = (els != 2'h0) && (mode != TCC_MODE_CAPTURE);

    // ****************************************
    // flag clear sequence and registers
    // ****************************************
    logic csr_wr, csr_rd, flag_wz;
    assign csr_wr = wr && hit(PADDR, `TCC_ADDR_CSR);
    assign csr_rd = rd && hit(PADDR, `TCC_ADDR_CSR);
    assign flag_wz = csr_wr && !PWDATA[`TCC_BIT_FLAG];

    always_comb begin
        csr_d = csr_q;
        clr_d = clr_q;
        cpwm_d = cpwm_q;
        mod_d = mod_q;
        cmp_d = cmp_q;
        if (csr_wr) begin
            // flag and unused bits keep their own rules, only masked bits follow the write
            csr_d = (csr_q & ~`TCC_CSR_WMASK) | (PWDATA[7:0] & `TCC_CSR_WMASK);
            cpwm_d = PWDATA[`TCC_BIT_CPWM];
        end
        if (wr && hit(PADDR, `TCC_ADDR_MOD))
            mod_d = PWDATA[15:0];
        if (wr && hit(PADDR, `TCC_ADDR_CMP))
            cmp_d = PWDATA[15:0];
        if (mode == TCC_MODE_CAPTURE && cap_edge && els != 2'h0)
            cmp_d = cnt_q;
        unique case (clr_q)
            // arm on the value software really saw, not on a flag set after setup
            TCC_CLR_IDLE: if (csr_rd && rdata_q[`TCC_BIT_FLAG]) clr_d = TCC_CLR_ARMED;
            TCC_CLR_ARMED: begin
                if (flag_wz) begin
                    csr_d[`TCC_BIT_FLAG] = 1'b0;
                    clr_d = TCC_CLR_IDLE;
                end
            end
        endcase
        // set wins, and a fresh event disarms a pending clear
        if (event_hit) begin
            csr_d[`TCC_BIT_FLAG] = 1'b1;
            clr_d = TCC_CLR_IDLE;
        end
        csr_d[1:0] = 2'h0;
    end

    always_comb begin
        coh_d = csr_wr;
        perr_d = 1'b0;
        rdata_d = 32'h0000_0000;
        if (hit(PADDR, `TCC_ADDR_CSR))
            rdata_d = {24'h00_0000, csr_q[7:2], 1'b0, cpwm_q};
        else if (hit(PADDR, `TCC_ADDR_MOD))
            rdata_d = {16'h0000, mod_q};
        else if (hit(PADDR, `TCC_ADDR_CMP))
            rdata_d = {16'h0000, cmp_q};
        else if (hit(PADDR, `TCC_ADDR_CNT))
            rdata_d = {16'h0000, cnt_q};
        else
            perr_d = 1'b1;
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            csr_q <= 8'h00;
            cpwm_q <= 1'b0;
            clr_q <= TCC_CLR_IDLE;
            mod_q <= 16'h0000;
            cmp_q <= 16'h0000;
            cnt_q <= 16'h0000;
            down_q <= 1'b0;
            pin_q <= 1'b0;
            coh_q <= 1'b0;
        end else begin
            csr_q <= csr_d;
            cpwm_q <= cpwm_d;
            clr_q <= clr_d;
            mod_q <= mod_d;
            cmp_q <= cmp_d;
            cnt_q <= cnt_d;
            down_q <= down_d;
            pin_q <= pin_d;
            coh_q <= coh_d;
        end
    end

    assign PRDATA = rdata_q;
    assign PSLVERR = perr_q && acc;
    always_ff @(posedge CLK) begin
        if (SRST) begin
            rdata_q <= 32'h0000_0000;
            perr_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            perr_q <= perr_d;
        end
    end

    assign IRQ = csr_q[`TCC_BIT_FLAG] && csr_q[`TCC_BIT_IE];
    assign MODE = mode;
    assign COH_RELEASE = coh_q;

    // ****************************************
    // checks
    // ****************************************
    property p_irq;
        @(posedge CLK) disable iff (SRST)
            IRQ == (csr_q[`TCC_BIT_FLAG] && csr_q[`TCC_BIT_IE]);
    endproperty
    a_irq: assert property (p_irq) else $error("irq mismatch");
    property p_set;
        @(posedge CLK) disable iff (SRST) event_hit |=> csr_q[`TCC_BIT_FLAG];
    endproperty
    a_set: assert property (p_set) else $error("event lost");
    property p_clr;
        @(posedge CLK) disable iff (SRST)
            $fell(csr_q[`TCC_BIT_FLAG]) |-> $past(clr_q) == TCC_CLR_ARMED && $past(flag_wz);
    endproperty
    a_clr: assert property (p_clr) else $error("flag cleared without sequence");
    property p_w1;
        @(posedge CLK) disable iff (SRST)
            csr_wr && PWDATA[`TCC_BIT_FLAG] && !csr_q[`TCC_BIT_FLAG] && !event_hit
            |=> !csr_q[`TCC_BIT_FLAG];
    endproperty
    a_w1: assert property (p_w1) else $error("write one set flag");
    sequence s_arm_read;
        csr_rd && rdata_q[`TCC_BIT_FLAG] && !event_hit;
    endsequence
    property p_arm;
        @(posedge CLK) disable iff (SRST) s_arm_read |=> clr_q == TCC_CLR_ARMED;
    endproperty
    a_arm: assert property (p_arm) else $error("clear not armed by read");
    sequence s_clear_req;
        clr_q == TCC_CLR_ARMED && flag_wz && !event_hit;
    endsequence
    property p_clr_done;
        @(posedge CLK) disable iff (SRST) s_clear_req |=> !csr_q[`TCC_BIT_FLAG];
    endproperty
    a_clr_done: assert property (p_clr_done) else $error("armed clear left flag set");
    property p_low;
        @(posedge CLK) disable iff (SRST) csr_q[1:0] == 2'h0;
    endproperty
    a_low: assert property (p_low) else $error("unused bits set");
    property p_gpio;
        @(posedge CLK) disable iff (SRST) els == 2'h0 |-> !PIN_OE;
    endproperty
    a_gpio: assert property (p_gpio) else $error("pin driven while released");
    property p_coh;
        @(posedge CLK) disable iff (SRST) csr_wr |=> COH_RELEASE;
    endproperty
    a_coh: assert property (p_coh) else $error("latch not released");
    property p_cpwm;
        @(posedge CLK) disable iff (SRST) cpwm_q |-> MODE == TCC_MODE_CPWM;
    endproperty
    a_cpwm: assert property (p_cpwm) else $error("center mode not forced");
endmodule : tcc_top
`default_nettype wire

// ---- tb/tb.sv ----
// self-checking bench for the timer channel control block
`timescale 1ns/1ns
`default_nettype none
`include "tcc_consts.svh"
module tb;
    import tcc_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready, pslverr, pin_line, pin_o, pin_oe, irq, coh, er;
    logic lvl = 1'b0;
    logic [31:0] rd;
    tcc_mode_t mode;
    logic [7:0] cfg [6] = '{8'h04, 8'h14, 8'h24, 8'h38, 8'h10, 8'h20};
    tcc_mode_t mds [6] = '{TCC_MODE_CAPTURE, TCC_MODE_COMPARE, TCC_MODE_EPWM,
        TCC_MODE_EPWM, TCC_MODE_COMPARE, TCC_MODE_EPWM};
    logic oes [6] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
    int err_count = 0;
    int samples_checked = 0;
    always #4 clk = ~clk;
    tcc_top tcc_top_inst (.CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .PIN_I(pin_line), .PIN_O(pin_o),
        .PIN_OE(pin_oe), .IRQ(irq), .MODE(mode), .COH_RELEASE(coh));
    tcc_pin_model tcc_pin_model_inst (.clk(clk), .lvl_req(lvl), .pin_o(pin_o),
        .pin_oe(pin_oe), .pin_line(pin_line));
    // ****************
    // helpers
    // ****************
    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task wr_coh(input logic [11:0] a, input logic [31:0] d, input logic exp);
        logic c;
        c = 1'b0;
        apb(1'b1, a, d);
        repeat (2) begin
            @(posedge clk);
            c = c | coh;
        end
        chk("coh", {31'h0, c}, {31'h0, exp});
    endtask : wr_coh
    task flag_is(input logic f, input logic ie);
        apb(1'b0, `TCC_ADDR_CSR, 32'h0);
        chk("flag", {31'h0, rd[7]}, {31'h0, f});
        chk("irq", {31'h0, irq}, {31'h0, f & ie});
    endtask : flag_is
    task pin_to(input logic v);
        lvl <= v;
        repeat (8) @(posedge clk);
    endtask : pin_to
    // ****************
    // scenarios
    // ****************
    task t_reset;
        apb(1'b0, `TCC_ADDR_CSR, 32'h0);
        chk("csr", rd, 32'h0);
        chk("mode", 32'(mode), 32'(TCC_MODE_CAPTURE));
        apb(1'b0, 12'h010, 32'h0);
        chk("err", {31'h0, er}, 32'h1);
        chk("rdx", rd, 32'h0);
    endtask : t_reset
    task t_regs;
        wr_coh(`TCC_ADDR_CSR, 32'h000000FF, 1'b1);
        apb(1'b0, `TCC_ADDR_CSR, 32'h0);
        chk("csr", rd, 32'h0000007D);
        chk("mode", 32'(mode), 32'(TCC_MODE_CPWM));
        chk("oe", {31'h0, pin_oe}, 32'h1);
    endtask : t_regs
    task t_modes;
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, `TCC_ADDR_CSR, {24'h0, cfg[i]});
            @(posedge clk);
            chk("mode", 32'(mode), 32'(mds[i]));
            chk("oe", {31'h0, pin_oe}, {31'h0, oes[i]});
        end
    endtask : t_modes
    task t_capture;
        // clear stale flag after reconfiguring
        apb(1'b1, `TCC_ADDR_CSR, 32'h44);
        apb(1'b0, `TCC_ADDR_CSR, 32'h0);
        apb(1'b1, `TCC_ADDR_CSR, 32'h44);
        flag_is(1'b0, 1'b1);
        pin_to(1'b1);
        flag_is(1'b1, 1'b1);
        apb(1'b1, `TCC_ADDR_CSR, 32'h44);
        flag_is(1'b0, 1'b1);
        pin_to(1'b0);
        flag_is(1'b0, 1'b1);
        apb(1'b1, `TCC_ADDR_CSR, 32'h4C);
        pin_to(1'b1);
        apb(1'b1, `TCC_ADDR_CSR, 32'hCC);
        apb(1'b1, `TCC_ADDR_CSR, 32'h4C);
        flag_is(1'b1, 1'b1);
        pin_to(1'b0);
        apb(1'b1, `TCC_ADDR_CSR, 32'h4C);
        flag_is(1'b1, 1'b1);
        apb(1'b1, `TCC_ADDR_CSR, 32'h08);
        flag_is(1'b0, 1'b0);
        pin_to(1'b1);
        flag_is(1'b0, 1'b0);
        pin_to(1'b0);
        flag_is(1'b1, 1'b0);
    endtask : t_capture
    task t_compare;
        // mid-run reset: flag must drop, and control bits and mode return to their reset values
        srst <= 1'b1;
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        flag_is(1'b0, 1'b0);
        chk("csr", rd, 32'h0);
        chk("mode", 32'(mode), 32'(TCC_MODE_CAPTURE));
        apb(1'b1, `TCC_ADDR_CSR, 32'h08);
        wr_coh(`TCC_ADDR_MOD, 32'h1F, 1'b0);
        wr_coh(`TCC_ADDR_CMP, 32'h10, 1'b0);
        apb(1'b1, `TCC_ADDR_CSR, 32'h1C);
        repeat (40) @(posedge clk);
        flag_is(1'b1, 1'b0);
        chk("pin", {31'h0, pin_o}, 32'h1);
        apb(1'b1, `TCC_ADDR_CSR, 32'h18);
        repeat (40) @(posedge clk);
        chk("pin", {31'h0, pin_o}, 32'h0);
        flag_is(1'b1, 1'b0);
        apb(1'b1, `TCC_ADDR_CSR, 32'h09);
        repeat (80) @(posedge clk);
        flag_is(1'b1, 1'b0);
    endtask : t_compare
    // ****************
    // run control
    // ****************
    task give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict
    initial begin
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        t_reset;
        t_regs;
        t_modes;
        t_capture;
        t_compare;
        give_verdict;
    end
    // a hung handshake never reaches the verdict otherwise
    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        give_verdict;
    end
endmodule : tb
`default_nettype wire

// ---- tb/tcc_pin_model.sv ----
// far-side pin model: external driver sharing the timer pin
`timescale 1ns/1ns
`default_nettype none
module tcc_pin_model (
    // clock
    input wire logic clk,
    // level wanted by the bench
    input wire logic lvl_req,
    // design side of the pin
    input wire logic pin_o,
    input wire logic pin_oe,
    output logic pin_line
);
    logic ext_q;
    // level moves only on a clock edge, so it stays steady for whole cycles
    always_ff @(posedge clk) begin
        ext_q <= lvl_req;
    end
    // channel drive wins while it owns the pin
    assign pin_line = pin_oe ? pin_o : ext_q;
endmodule : tcc_pin_model
`default_nettype wire
